// ===== dv/sdtc_card_model.sv
// Purpose: card side byte pacing for the data channel
// Assumes: busy is high while a data phase runs
// Notes: slow mode moves one byte every fourth cycle
`timescale 1ns/1ps
module sdtc_card_model (
  input wire clk,
  input wire reset,
  input wire busy,
  input wire slow,
  output reg byte_strobe
);
  reg [1:0] gap_reg;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_reg <= 2'h0;
      byte_strobe <= 1'b0;
    end else begin
      gap_reg <= gap_reg + 2'h1;
      // one strobe per byte moved
      byte_strobe <= busy && (!slow || gap_reg == 2'h3);
    end
  end
endmodule // sdtc_card_model

// ===== dv/sdtc_data_transfer_control_bench.sv
// Purpose: self-checking bench for the control bank
// Assumes: one wait state per bus access
// Notes: lengths kept short so the run stays brief
`timescale 1ns/1ps
`include "sdtc_defines.vh"
module sdtc_data_transfer_control_bench;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h00000000;
  reg slow = 1'b0;
  reg [31:0] rd_data;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, byte_strobe, fsm_send_wait, fsm_recv_wait;
  wire fsm_read_wait, dma_request, stream_mode, card_to_host;
  wire read_wait_drive, transfer_done;
  wire [14:0] block_bytes;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer i, j;
  sdtc_data_transfer_control u_sdtc_data_transfer_control (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .byte_strobe(byte_strobe), .fsm_send_wait(fsm_send_wait),
    .fsm_recv_wait(fsm_recv_wait), .fsm_read_wait(fsm_read_wait),
    .dma_request(dma_request), .stream_mode(stream_mode),
    .card_to_host(card_to_host), .read_wait_drive(read_wait_drive),
    .block_bytes(block_bytes), .transfer_done(transfer_done));
  sdtc_card_model u_sdtc_card_model (.clk(clk), .reset(reset),
    .busy(fsm_send_wait | fsm_recv_wait), .slow(slow),
    .byte_strobe(byte_strobe));
  task end_sim;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  // rw high writes; request held until waitrequest seen low
  task bus(input rw, input [5:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= rw;
      avs_read <= !rw;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task wdone;
    begin
      j = 0;
      while (transfer_done !== 1'b1 && j < 300) begin
        step(1);
        j = j + 1;
      end
      chk(transfer_done, 1);
    end
  endtask
  task t_size;
    for (i = 0; i < 16; i = i + 1) begin
      bus(1, `SDTC_OFS_CTRL, i << 4);
      step(2);
      chk(block_bytes, i == 15 ? 0 : 1 << i);
    end
  endtask
  task t_send;
    begin
      bus(1, `SDTC_OFS_LEN, 3);
      bus(1, `SDTC_OFS_CTRL, 32'h39);
      step(1);
      chk({fsm_send_wait, dma_request}, 2'h3);
      wdone;
      step(3);
      chk(fsm_send_wait, 0);
      bus(0, `SDTC_OFS_STAT, 0);
      chk(rd_data, 32'h11);
      bus(0, `SDTC_OFS_STAT, 0);
      chk(rd_data, 32'h01);
      bus(0, `SDTC_OFS_CNT, 0);
      chk(rd_data, 0);
      slow <= 1'b1;
      bus(1, `SDTC_OFS_CTRL, 32'h39);
      step(1);
      chk(fsm_send_wait, 1);
      wdone;
      slow <= 1'b0;
    end
  endtask
  task t_recv;
    begin
      bus(1, `SDTC_OFS_LEN, 2);
      bus(1, `SDTC_OFS_CTRL, 32'h07);
      step(1);
      // stream inbound, dma off
      chk({fsm_recv_wait, stream_mode, card_to_host, dma_request},
        4'hE);
      wdone;
      bus(1, `SDTC_OFS_CTRL, 32'h103);
      step(1);
      chk({fsm_read_wait, read_wait_drive}, 2'h3);
      bus(1, `SDTC_OFS_CTRL, 32'h02);
      step(2);
      chk({fsm_read_wait, read_wait_drive}, 0);
      wdone;
    end
  endtask
  task t_lock;
    begin
      bus(1, `SDTC_OFS_DATA, 0);
      bus(1, `SDTC_OFS_CTRL, 32'h50);
      bus(0, `SDTC_OFS_CTRL, 0);
      chk(rd_data, 32'h02);
      step(8);
      bus(1, `SDTC_OFS_CTRL, 32'h50);
      bus(0, `SDTC_OFS_CTRL, 0);
      chk(rd_data, 32'h50);
      bus(1, `SDTC_OFS_CTRL, 32'hF1);
      step(2);
      chk({fsm_send_wait, fsm_recv_wait}, 0);
      bus(1, 6'h3C, 32'hFFFFFFFF);
      bus(0, 6'h3C, 0);
      chk(rd_data, 0);
    end
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    step(1);
    chk(block_bytes, 1);
    bus(0, `SDTC_OFS_CTRL, 0);
    chk(rd_data, 0);
    t_size;
    t_send;
    t_recv;
    t_lock;
    end_sim;
  end
  // far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule // sdtc_data_transfer_control_bench

// ===== dv/sdtc_monitor.sv
// Purpose: port checker for the control bank
// Assumes: single clock domain
// Notes: bound to the top module by name
`timescale 1ns/1ps
module sdtc_monitor (
  input wire clk,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire fsm_send_wait,
  input wire fsm_recv_wait,
  input wire fsm_read_wait,
  input wire card_to_host,
  input wire transfer_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence busy_s;
    fsm_send_wait || fsm_recv_wait;
  endsequence
  wait_ans_a: assert property (req_s |=> !avs_waitrequest)
    else $error("bus request not answered");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  fsm_hot_a: assert property ($onehot0({fsm_send_wait,
    fsm_recv_wait, fsm_read_wait})) else $error("state not one-hot");
  send_dir_a: assert property ($rose(fsm_send_wait) |-> !card_to_host)
    else $error("send wait with inbound direction");
  recv_dir_a: assert property ($rose(fsm_recv_wait) |-> card_to_host)
    else $error("receive wait with outbound direction");
  rwait_dir_a: assert property (fsm_read_wait |-> card_to_host)
    else $error("read wait on outbound transfer");
  done_pulse_a: assert property (transfer_done |=> !transfer_done)
    else $error("done longer than one cycle");
  done_src_a: assert property (transfer_done |-> $past(fsm_send_wait ||
    fsm_recv_wait)) else $error("done without a data phase");
  done_idle_a: assert property (transfer_done |-> not busy_s)
    else $error("done while a data phase still runs");
endmodule // sdtc_monitor
bind sdtc_data_transfer_control sdtc_monitor u_sdtc_monitor (.*);

// ===== src/sdtc_data_transfer_control.v
// Purpose: data transfer control register and data channel fsm
// Assumes: avalon-mm slave, 10 MHz clk, one byte moved per byte_strobe
// Notes: card-side shifting lives in a neighbouring block
//
// How it works
// - block size code n below 1111 gives 2^n bytes; 1111 gives 0
// - codes 0000..0010 give 1, 2, 4 bytes
// - bit 3 enables dma requests, reset 0
// - bit 2 selects stream, else block mode
// - bit 1 set means card to host
// - launch enters send or receive wait
// - read wait set at a card to host launch enters read wait
// - control writes ignored seven clocks after data write
// - read wait begin drives read wait signalling
// - counter loads length, counts down, then completes
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "sdtc_defines.vh"
module sdtc_data_transfer_control (
  input wire clk,
  input wire reset,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire byte_strobe,
  output reg fsm_send_wait,
  output reg fsm_recv_wait,
  output reg fsm_read_wait,
  output reg dma_request,
  output reg stream_mode,
  output reg card_to_host,
  output reg read_wait_drive,
  output reg [14:0] block_bytes,
  output reg transfer_done
);
  // ***************************
  // state encoding
  // ***************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEND = 4'h2;
  localparam [3:0] ST_RECV = 4'h4;
  localparam [3:0] ST_RWAIT = 4'h8;

  reg [11:0] ctrl_reg;
  reg [24:0] len_reg;
  reg [31:0] tmo_reg;
  reg [24:0] cnt_reg;
  reg [24:0] cnt_next;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] lock_reg;
  reg launch_reg;
  reg done_flag_reg;
  reg ack_reg;
  reg [31:0] rdata_next;
  wire [31:0] wmask;
  wire [3:0] bsz_code;
  wire bus_req;
  wire ctrl_wr;
  wire data_wr;
  wire clr_done;
  wire [31:0] ctrl_merged;
  wire wr_fire;
  wire rd_fire;
  wire len_wr;
  wire tmo_wr;
  wire launch_ok;
  wire data_phase;
  wire leaving_data;

  // ***************************
  // avalon slave
  // ***************************
  // one wait state: request taken when ack_reg rises, answered next edge
  assign bus_req = (avs_read | avs_write) & ~ack_reg;
  // side effects land on the edge that sees waitrequest low, so a
  // master that gives up early never leaves a half-done write behind
  assign wr_fire = avs_write & ack_reg;
  assign rd_fire = avs_read & ack_reg;
  assign data_wr = wr_fire & (avs_address == `SDTC_OFS_DATA);
  // control writes inside the lockout window are dropped silently
  assign ctrl_wr = wr_fire & (avs_address == `SDTC_OFS_CTRL) &
                   (lock_reg == 3'h0);
  assign len_wr = wr_fire & (avs_address == `SDTC_OFS_LEN);
  assign tmo_wr = wr_fire & (avs_address == `SDTC_OFS_TMO);
  assign clr_done = rd_fire & (avs_address == `SDTC_OFS_STAT);
  assign bsz_code = ctrl_reg[`SDTC_BSZ_HI:`SDTC_BSZ_LO];

  // ***************************
  // byte lanes
  // ***************************
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign wmask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
    end
  endgenerate
  assign ctrl_merged = ({20'h00000, ctrl_reg} & ~wmask) |
                       (avs_writedata & wmask);

  always @* begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `SDTC_OFS_CTRL: rdata_next = {20'h00000, ctrl_reg};
      `SDTC_OFS_LEN: rdata_next = {7'h00, len_reg};
      `SDTC_OFS_TMO: rdata_next = tmo_reg;
      `SDTC_OFS_CNT: rdata_next = {7'h00, cnt_reg};
      `SDTC_OFS_STAT: rdata_next = {27'h0000000, done_flag_reg, state_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      avs_waitrequest <= ~bus_req;
      if (bus_req & avs_read) begin
        avs_readdata <= rdata_next;
      end
    end
  end

  // ***************************
  // registers
  // ***************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      launch_reg <= 1'b0;
    end else begin
      // launch is a pulse on each control rewrite with bit 0 set
      launch_reg <= ctrl_wr & avs_writedata[`SDTC_BIT_LAUNCH] &
                    avs_byteenable[0];
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `SDTC_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ctrl_merged[11:0] & `SDTC_CTRL_MASK;
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      len_reg <= `SDTC_LEN_RST;
    end else begin
      if (len_wr) begin
        len_reg <= (len_reg & ~wmask[24:0]) |
                   (avs_writedata[24:0] & wmask[24:0]);
      end
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tmo_reg <= `SDTC_TMO_RST;
    end else begin
      // held for the timer block; no timeout action lives here
      if (tmo_wr) begin
        tmo_reg <= (tmo_reg & ~wmask) | (avs_writedata & wmask);
      end
    end
  end

  // ***************************
  // write lockout
  // ***************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_reg <= 3'h0;
    end else begin
      // each data write restarts the window
      if (data_wr) begin
        lock_reg <= `SDTC_LOCK_CYCLES;
      end else if (lock_reg != 3'h0) begin
        lock_reg <= lock_reg - 3'h1;
      end
    end
  end

  // ***************************
  // data channel fsm
  // ***************************
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (launch_reg & launch_ok) begin
          cnt_next = len_reg;
          if (ctrl_reg[`SDTC_BIT_RWAIT] & ctrl_reg[`SDTC_BIT_DIR]) begin
            state_next = ST_RWAIT;
          end else if (ctrl_reg[`SDTC_BIT_DIR]) begin
            state_next = ST_RECV;
          end else begin
            state_next = ST_SEND;
          end
        end
      end
      ST_SEND, ST_RECV: begin
        if (cnt_reg == 25'h0000000) begin
          state_next = ST_IDLE;
        end else if (byte_strobe) begin
          cnt_next = cnt_reg - 25'h0000001;
        end
      end
      ST_RWAIT: begin
        // leaves once software drops read wait begin
        if (~ctrl_reg[`SDTC_BIT_RWAIT]) begin
          state_next = ST_RECV;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // reserved size only blocks block mode; stream ignores size
  assign launch_ok = ctrl_reg[`SDTC_BIT_STREAM] |
                     (bsz_code != `SDTC_BSZ_RSVD);
  assign data_phase = (state_reg == ST_SEND) | (state_reg == ST_RECV);
  // read wait hands over to receive, so it never reports completion
  assign leaving_data = data_phase & (state_next == ST_IDLE);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 25'h0000000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // ***************************
  // completion
  // ***************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      transfer_done <= 1'b0;
      done_flag_reg <= 1'b0;
    end else begin
      transfer_done <= leaving_data;
      // set wins over read-to-clear
      if (leaving_data) begin
        done_flag_reg <= 1'b1;
      end else if (clr_done) begin
        done_flag_reg <= 1'b0;
      end
    end
  end

  // ***************************
  // phase outputs
  // ***************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fsm_send_wait <= 1'b0;
      fsm_recv_wait <= 1'b0;
      fsm_read_wait <= 1'b0;
      dma_request <= 1'b0;
    end else begin
      // taken from state_next so the pins line up with state_reg
      fsm_send_wait <= (state_next == ST_SEND);
      fsm_recv_wait <= (state_next == ST_RECV);
      fsm_read_wait <= (state_next == ST_RWAIT);
      dma_request <= ctrl_reg[`SDTC_BIT_DMA] &
                     (state_next != ST_IDLE);
    end
  end

  // ***************************
  // mode outputs
  // ***************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stream_mode <= 1'b0;
      card_to_host <= 1'b0;
      read_wait_drive <= 1'b0;
    end else begin
      stream_mode <= ctrl_reg[`SDTC_BIT_STREAM];
      card_to_host <= ctrl_reg[`SDTC_BIT_DIR];
      read_wait_drive <= ctrl_reg[`SDTC_BIT_RWAIT];
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      block_bytes <= 15'h0001;
    end else begin
      // reserved code reads as 0 bytes
      if (bsz_code == `SDTC_BSZ_RSVD) begin
        block_bytes <= 15'h0000;
      end else begin
        block_bytes <= 15'h0001 << bsz_code;
      end
    end
  end
endmodule // sdtc_data_transfer_control

// ===== src/sdtc_defines.vh
// Purpose: constants for the sd data transfer control bank
// Assumes: avalon-mm word addressing by byte offset, 32-bit data
// Notes: offsets are byte addresses
`ifndef SDTC_DEFINES_VH
`define SDTC_DEFINES_VH
// ***************************
// register offsets
// ***************************
`define SDTC_OFS_CTRL 6'h00
`define SDTC_OFS_LEN 6'h04
`define SDTC_OFS_TMO 6'h08
`define SDTC_OFS_CNT 6'h0C
`define SDTC_OFS_STAT 6'h10
`define SDTC_OFS_DATA 6'h14
// ***************************
// control fields
// ***************************
`define SDTC_BIT_LAUNCH 0
`define SDTC_BIT_DIR 1
`define SDTC_BIT_STREAM 2
`define SDTC_BIT_DMA 3
`define SDTC_BSZ_LO 4
`define SDTC_BSZ_HI 7
`define SDTC_BIT_RWAIT 8
`define SDTC_BSZ_RSVD 4'hF
`define SDTC_CTRL_MASK 12'h1FF
`define SDTC_CTRL_RST 12'h000
`define SDTC_LEN_RST 25'h0000000
`define SDTC_TMO_RST 32'h00000000
// ***************************
// timing
// ***************************
`define SDTC_LOCK_CYCLES 3'h7
`endif
